// file: sup_pkg.sv
// sup_pkg: constants shared by the supervisor device end and the host end.
// assumes a single 25 MHz clock shared by both ends of the link.
package sup_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_FREQ_HZ = 25000000;
  localparam int HZ_PER_KHZ = 1000;
  localparam int HZ_PER_MHZ = 1000000;
  localparam int MS_CYCLES = CLK_FREQ_HZ / HZ_PER_KHZ;
  localparam int RESET_FILTER_TIME_US = 10;
  localparam int RESET_FILTER_CYCLES =
    (RESET_FILTER_TIME_US * CLK_FREQ_HZ + HZ_PER_MHZ - 1) / HZ_PER_MHZ;
  localparam int RESET_DELAY_TIME_MS = 10;
  localparam int LONG_OPEN_WINDOW_TIME_MS = 200;
  localparam int WD_CLOSED_PCT = 60;
  localparam int PCT_FULL = 100;
  localparam logic [10:0] WD_PERIOD_1_MS = 11'h00A;
  localparam logic [10:0] WD_PERIOD_2_MS = 11'h014;
  localparam logic [10:0] WD_PERIOD_3_MS = 11'h032;
  localparam logic [10:0] WD_PERIOD_4_MS = 11'h064;
  localparam logic [10:0] WD_PERIOD_5_MS = 11'h0C8;
  localparam logic [10:0] WD_PERIOD_6_MS = 11'h1F4;
  localparam logic [10:0] WD_PERIOD_7_MS = 11'h3E8;
  localparam int FRAME_LEN_CYCLES = 4;

  // ****************************************
  // device register map on the link
  // ****************************************
  localparam logic [1:0] DEV_MODE_CTRL = 2'h0;
  localparam logic [1:0] DEV_WDOG_CTRL = 2'h1;
  localparam logic [1:0] DEV_SUP_CFG = 2'h2;
  localparam logic [1:0] DEV_SUP_STAT = 2'h3;
  localparam int MODE_FIELD_LSB = 0;
  localparam logic [1:0] MODE_WR_NORMAL = 2'h0;
  localparam logic [1:0] MODE_WR_SLEEP = 2'h1;
  localparam logic [1:0] MODE_WR_STOP = 2'h2;
  localparam logic [1:0] MODE_WR_SOFT_RESET = 2'h3;
  localparam int WD_PERIOD_LSB = 0;
  localparam int WD_RSVD_BIT = 3;
  localparam int WD_TYPE_BIT = 4;
  localparam int WD_CHK_BIT = 7;
  localparam logic [2:0] WD_PERIOD_DEFAULT = 3'h4;
  localparam logic WD_TYPE_DEFAULT = 1'b0;
  localparam int CFG_SOFT_RO_BIT = 0;
  localparam int CFG_THR_LSB = 1;
  localparam logic SOFT_RO_DEFAULT = 1'b1;
  localparam logic [1:0] THRESHOLD_DEFAULT = 2'h0;
  localparam logic [1:0] CFG_SEL_CONFIG2 = 2'h1;
  localparam logic [1:0] FAIL_MAX_CONFIG2 = 2'h1;
  localparam logic [1:0] FAIL_MAX_OTHER = 2'h2;

  // ****************************************
  // host register map on the user port
  // ****************************************
  localparam logic [3:0] HOST_DATA = 4'h0;
  localparam logic [3:0] HOST_CMD = 4'h4;
  localparam logic [3:0] HOST_STAT = 4'h8;
  localparam int HOST_CMD_WRITE_BIT = 2;
  localparam int HOST_STAT_BUSY_BIT = 0;
  localparam int HOST_STAT_RESET_BIT = 1;
  localparam int HOST_STAT_RDATA_LSB = 8;

  typedef enum logic [5:0] {
    M_INIT     = 6'b00_0001,
    M_NORMAL   = 6'b00_0010,
    M_STOP     = 6'b00_0100,
    M_SLEEP    = 6'b00_1000,
    M_RESTART  = 6'b01_0000,
    M_FAILSAFE = 6'b10_0000
  } mode_t;

  typedef enum logic [2:0] {
    H_IDLE  = 3'b001,
    H_FRAME = 3'b010,
    H_END   = 3'b100
  } host_state_t;

endpackage

// file: sup_if.sv
// sup_if: link between host and supervisor: frame lines, read data, reset line.
// assumes both ends run on the same clock; no wire is shared in both directions.
`timescale 1ns/100ps
interface sup_if;
  logic chip_select_n;
  logic frame_write;
  logic [1:0] frame_addr;
  logic [7:0] frame_data;
  logic [7:0] read_data;
  logic reset_out_n;

  modport device (
    input chip_select_n,
    input frame_write,
    input frame_addr,
    input frame_data,
    output read_data,
    output reset_out_n
  );

  modport host (
    output chip_select_n,
    output frame_write,
    output frame_addr,
    output frame_data,
    input read_data,
    input reset_out_n
  );
endinterface

// file: sup_device.sv
// sup_device: reset output, watchdog, failure counter and mode sequencing.
// assumes the host holds frame lines stable from frame start until one cycle
// after chip_select_n rises; analog comparator and wake inputs are async pins.
//
// Behaviour
// - reset low after filter, held event plus delay
// - power-up holds reset until supply good plus delay
// - reset threshold selectable, default after reset
// - mode write 11 soft-resets to init, defaults
// - soft reset honoured only in normal or stop
// - config bit chooses soft reset driving reset
// - type bit default timeout, writable normal only
// - long window after init or restart release, stop exit, soft reset
// - new timing restarts watchdog at once
// - trigger is watchdog write, executed on select rise
// - long open window lasts 200 ms
// - seven periods 10 to 1000 ms
// - failure enters restart or fail-safe, then normal
// - development mode keeps watchdog off
// - bad trigger counts, saturating per configuration
// - counter clears on good trigger or in sleep
// - timeout: trigger anytime restarts, expiry resets
// - window: 60 percent closed, then open
// - host triggers between 0.72 and 1.00 period
// - even parity over data, else ignore, flag
// - parity uses written reserved bit 3
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/100ps
module sup_device
  import sup_pkg::*;
#(
  parameter int unsigned CYCLES_PER_MS = MS_CYCLES
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic VCC_UNDERVOLTAGE,
  input wire logic DEV_MODE,
  input wire logic WAKE,
  input wire logic FAILSAFE_ON_WDOG,
  input wire logic [1:0] CFG_SEL,
  output logic [1:0] THRESHOLD_SEL,
  sup_if.device link
);

  // ****************************************
  // checks and lookups
  // ****************************************
  if (CYCLES_PER_MS < 2 || CYCLES_PER_MS > 65536) begin : g_chk
    $error("CYCLES_PER_MS out of range");
  end

  function automatic logic [10:0] period_ms(input logic [2:0] sel);
    logic [10:0] p;
    p = WD_PERIOD_1_MS;
    unique case (sel)
      3'h2: p = WD_PERIOD_2_MS;
      3'h3: p = WD_PERIOD_3_MS;
      3'h4: p = WD_PERIOD_4_MS;
      3'h5: p = WD_PERIOD_5_MS;
      3'h6: p = WD_PERIOD_6_MS;
      3'h7: p = WD_PERIOD_7_MS;
      default: p = WD_PERIOD_1_MS;
    endcase
    return p;
  endfunction

  function automatic logic [10:0] closed_ms(input logic [10:0] p);
    int c;
    c = int'(p) * WD_CLOSED_PCT / PCT_FULL;
    return c[10:0];
  endfunction

  // ****************************************
  // pin synchronisers and frame end
  // ****************************************
  logic [2:0] pin_s1_reg;
  logic [2:0] pin_s2_reg;
  logic uv_s;
  logic dev_s;
  logic wake_s;
  logic cs_prev_reg;
  logic frame_end;
  logic wr;

  always_ff @(posedge CLK) begin
    pin_s1_reg <= {WAKE, DEV_MODE, VCC_UNDERVOLTAGE};
    pin_s2_reg <= pin_s1_reg;
  end
  assign uv_s = pin_s2_reg[0];
  assign dev_s = pin_s2_reg[1];
  assign wake_s = pin_s2_reg[2];

  always_ff @(posedge CLK) begin
    if (RST) begin
      cs_prev_reg <= 1'b1;
    end else begin
      cs_prev_reg <= link.chip_select_n;
    end
  end
  assign frame_end = link.chip_select_n & ~cs_prev_reg;
  assign wr = frame_end & link.frame_write;

  // ****************************************
  // decoded commands
  // ****************************************
  mode_t mode_reg;
  logic [2:0] period_sel_reg;
  logic type_reg;
  logic soft_ro_reg;
  logic [1:0] fail_cnt_reg;
  logic serial_fail_reg;
  logic reset_low_reg;
  logic reset_low_d_reg;
  logic wd_on_reg;
  logic wd_long_reg;
  logic [10:0] wd_ms_reg;
  logic parity_ok;
  logic wd_wr;
  logic wd_valid;
  logic wd_set;
  logic mode_wr;
  logic [1:0] mode_val;
  logic soft_req;
  logic rel_pulse;
  logic uv_event_reg;
  logic wd_allowed;
  logic closed_hit;
  logic expire;
  logic wdog_fail_count;
  logic good_trig;
  logic start_long;
  logic [10:0] limit_ms;

  assign parity_ok = ~^link.frame_data;
  assign wd_wr = wr & (link.frame_addr == DEV_WDOG_CTRL);
  assign wd_valid = wd_wr & parity_ok;
  assign wd_set = wd_valid & (mode_reg == M_NORMAL);
  assign mode_wr = wr & (link.frame_addr == DEV_MODE_CTRL);
  assign mode_val = link.frame_data[MODE_FIELD_LSB +: 2];
  assign soft_req = mode_wr & (mode_val == MODE_WR_SOFT_RESET)
    & (mode_reg == M_NORMAL || mode_reg == M_STOP);

  // ****************************************
  // one millisecond tick
  // ****************************************
  logic [15:0] div_reg;
  logic ms_tick_reg;

  always_ff @(posedge CLK) begin
    if (RST || div_reg == 16'(CYCLES_PER_MS - 1)) begin
      div_reg <= 16'h0000;
    end else begin
      div_reg <= div_reg + 16'h0001;
    end
  end

  always_ff @(posedge CLK) begin
    ms_tick_reg <= ~RST && div_reg == 16'(CYCLES_PER_MS - 1);
  end

  // ****************************************
  // reset output
  // ****************************************
  logic [15:0] uv_cnt_reg;
  logic [7:0] rd_cnt_reg;
  logic cause;
  logic wake_restart;

  always_ff @(posedge CLK) begin
    if (RST || !uv_s) begin
      uv_cnt_reg <= 16'h0000;
      uv_event_reg <= 1'b0;
    end else if (uv_cnt_reg == 16'(RESET_FILTER_CYCLES - 1)) begin
      uv_event_reg <= 1'b1;
    end else begin
      uv_cnt_reg <= uv_cnt_reg + 16'h0001;
    end
  end

  assign wake_restart = wake_s & (mode_reg == M_SLEEP || mode_reg == M_FAILSAFE);
  assign cause = uv_event_reg | wdog_fail_count | (soft_req & soft_ro_reg) | wake_restart;

  always_ff @(posedge CLK) begin
    if (RST) begin
      reset_low_reg <= 1'b1;
      rd_cnt_reg <= 8'(RESET_DELAY_TIME_MS);
    end else if (cause) begin
      reset_low_reg <= 1'b1;
      rd_cnt_reg <= 8'(RESET_DELAY_TIME_MS);
    end else if (reset_low_reg && ms_tick_reg) begin
      if (rd_cnt_reg <= 8'h01) begin
        reset_low_reg <= 1'b0;
        rd_cnt_reg <= 8'h00;
      end else begin
        rd_cnt_reg <= rd_cnt_reg - 8'h01;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      reset_low_d_reg <= 1'b1;
      link.reset_out_n <= 1'b0;
    end else begin
      reset_low_d_reg <= reset_low_reg;
      link.reset_out_n <= ~reset_low_reg;
    end
  end
  assign rel_pulse = reset_low_d_reg & ~reset_low_reg;

  // ****************************************
  // modes
  // ****************************************
  always_ff @(posedge CLK) begin
    if (RST || soft_req) begin
      mode_reg <= M_INIT;
    end else if (wdog_fail_count) begin
      mode_reg <= FAILSAFE_ON_WDOG ? M_FAILSAFE : M_RESTART;
    end else if (uv_event_reg && mode_reg != M_SLEEP && mode_reg != M_FAILSAFE
        && mode_reg != M_INIT) begin
      mode_reg <= M_RESTART;
    end else begin
      unique case (mode_reg)
        M_INIT: if (mode_wr && mode_val == MODE_WR_NORMAL) mode_reg <= M_NORMAL;
        M_NORMAL: begin
          if (mode_wr && mode_val == MODE_WR_SLEEP) mode_reg <= M_SLEEP;
          else if (mode_wr && mode_val == MODE_WR_STOP) mode_reg <= M_STOP;
        end
        M_STOP: if (mode_wr && mode_val == MODE_WR_NORMAL) mode_reg <= M_NORMAL;
        M_SLEEP: if (wake_s) mode_reg <= M_RESTART;
        M_RESTART: if (rel_pulse) mode_reg <= M_NORMAL;
        M_FAILSAFE: if (wake_s) mode_reg <= M_RESTART;
      endcase
    end
  end

  // ****************************************
  // watchdog
  // ****************************************
  assign wd_allowed = ~dev_s & ~reset_low_reg
    & (mode_reg == M_INIT || mode_reg == M_NORMAL || mode_reg == M_STOP);
  assign limit_ms = wd_long_reg ? 11'(LONG_OPEN_WINDOW_TIME_MS)
    : period_ms(period_sel_reg);
  assign closed_hit = ~wd_long_reg & type_reg
    & (wd_ms_reg < closed_ms(period_ms(period_sel_reg)));
  assign expire = ms_tick_reg & (wd_ms_reg + 11'h001 >= limit_ms);
  assign wdog_fail_count = wd_allowed & wd_on_reg & ((wd_valid & closed_hit) | expire);
  assign good_trig = wd_allowed & wd_on_reg & wd_valid & ~closed_hit;
  assign start_long = (rel_pulse & (mode_reg == M_INIT || mode_reg == M_RESTART))
    | (soft_req & ~soft_ro_reg)
    | (mode_reg == M_STOP && mode_wr && mode_val == MODE_WR_NORMAL);

  always_ff @(posedge CLK) begin
    if (RST) begin
      wd_on_reg <= 1'b0;
      wd_long_reg <= 1'b0;
      wd_ms_reg <= 11'h000;
    end else if (start_long) begin
      wd_on_reg <= 1'b1;
      wd_long_reg <= 1'b1;
      wd_ms_reg <= 11'h000;
    end else if (!wd_allowed) begin
      wd_on_reg <= 1'b0;
      wd_ms_reg <= 11'h000;
    end else if (good_trig || (wd_on_reg && wd_set)) begin
      wd_long_reg <= 1'b0;
      wd_ms_reg <= 11'h000;
    end else if (wd_on_reg && ms_tick_reg) begin
      wd_ms_reg <= wd_ms_reg + 11'h001;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge CLK) begin
    if (RST || soft_req) begin
      period_sel_reg <= WD_PERIOD_DEFAULT;
      type_reg <= WD_TYPE_DEFAULT;
    end else if (wd_set) begin
      period_sel_reg <= link.frame_data[WD_PERIOD_LSB +: 3];
      type_reg <= link.frame_data[WD_TYPE_BIT];
    end
  end

  always_ff @(posedge CLK) begin
    if (RST || soft_req) begin
      soft_ro_reg <= SOFT_RO_DEFAULT;
      THRESHOLD_SEL <= THRESHOLD_DEFAULT;
    end else if (wr && link.frame_addr == DEV_SUP_CFG) begin
      soft_ro_reg <= link.frame_data[CFG_SOFT_RO_BIT];
      THRESHOLD_SEL <= link.frame_data[CFG_THR_LSB +: 2];
    end
  end

  always_ff @(posedge CLK) begin
    if (RST || soft_req) begin
      fail_cnt_reg <= 2'h0;
    end else if (wdog_fail_count) begin
      if (fail_cnt_reg < ((CFG_SEL == CFG_SEL_CONFIG2) ? FAIL_MAX_CONFIG2 : FAIL_MAX_OTHER)) begin
        fail_cnt_reg <= fail_cnt_reg + 2'h1;
      end
    end else if (good_trig || mode_reg == M_SLEEP) begin
      fail_cnt_reg <= 2'h0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST || soft_req) begin
      serial_fail_reg <= 1'b0;
    end else if (wd_wr && !parity_ok) begin
      serial_fail_reg <= 1'b1;
    end else if (wr && link.frame_addr == DEV_SUP_STAT) begin
      serial_fail_reg <= 1'b0;
    end
  end

  // ****************************************
  // read back
  // ****************************************
  logic [2:0] mode_idx;

  always_comb begin
    mode_idx = 3'h0;
    unique case (mode_reg)
      M_INIT: mode_idx = 3'h0;
      M_NORMAL: mode_idx = 3'h1;
      M_STOP: mode_idx = 3'h2;
      M_SLEEP: mode_idx = 3'h3;
      M_RESTART: mode_idx = 3'h4;
      M_FAILSAFE: mode_idx = 3'h5;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      link.read_data <= 8'h00;
    end else begin
      unique case (link.frame_addr)
        DEV_MODE_CTRL: link.read_data <= {5'h00, mode_idx};
        DEV_WDOG_CTRL: link.read_data <= {3'h0, type_reg, 1'b0, period_sel_reg};
        DEV_SUP_CFG: link.read_data <= {5'h00, THRESHOLD_SEL, soft_ro_reg};
        DEV_SUP_STAT: link.read_data <= {5'h00, serial_fail_reg, fail_cnt_reg};
      endcase
    end
  end

endmodule

// file: sup_host.sv
// sup_host: host end; turns user register writes into link frames.
// assumes a plain register port: one-cycle strobes, read data the cycle after.
`timescale 1ns/100ps
module sup_host
  import sup_pkg::*;
#(
  parameter int unsigned FRAME_CYCLES = FRAME_LEN_CYCLES
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WE,
  input wire logic RE,
  output logic [15:0] RDATA,
  sup_if.host link
);

  if (FRAME_CYCLES < 2 || FRAME_CYCLES > 255) begin : g_chk
    $error("FRAME_CYCLES out of range");
  end

  // ****************************************
  // user registers
  // ****************************************
  host_state_t state_reg;
  logic [7:0] data_reg;
  logic [7:0] last_rd_reg;
  logic [7:0] cnt_reg;
  logic launch;
  logic [7:0] frame_byte;

  assign launch = WE && ADDR == HOST_CMD && state_reg == H_IDLE;

  always_comb begin
    frame_byte = data_reg;
    if (WDATA[1:0] == DEV_WDOG_CTRL) begin
      frame_byte[WD_CHK_BIT] = ^data_reg[6:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      data_reg <= 8'h00;
    end else if (WE && ADDR == HOST_DATA) begin
      data_reg <= WDATA[7:0];
    end
  end

  // ****************************************
  // frame sequencer
  // ****************************************
  always_ff @(posedge CLK) begin
    if (RST) begin
      state_reg <= H_IDLE;
      cnt_reg <= 8'h00;
      link.chip_select_n <= 1'b1;
      link.frame_write <= 1'b0;
      link.frame_addr <= 2'h0;
      link.frame_data <= 8'h00;
      last_rd_reg <= 8'h00;
    end else begin
      unique case (state_reg)
        H_IDLE: begin
          if (launch) begin
            link.frame_addr <= WDATA[1:0];
            link.frame_write <= WDATA[HOST_CMD_WRITE_BIT];
            link.frame_data <= frame_byte;
            link.chip_select_n <= 1'b0;
            cnt_reg <= 8'h00;
            state_reg <= H_FRAME;
          end
        end
        H_FRAME: begin
          if (cnt_reg == 8'(FRAME_CYCLES - 1)) begin
            link.chip_select_n <= 1'b1;
            last_rd_reg <= link.read_data;
            state_reg <= H_END;
          end else begin
            cnt_reg <= cnt_reg + 8'h01;
          end
        end
        H_END: state_reg <= H_IDLE;
      endcase
    end
  end

  // ****************************************
  // read port
  // ****************************************
  always_ff @(posedge CLK) begin
    if (RST) begin
      RDATA <= 16'h0000;
    end else if (RE) begin
      unique case (ADDR)
        HOST_DATA: RDATA <= {8'h00, data_reg};
        HOST_STAT: RDATA <= {last_rd_reg, 6'h00, link.reset_out_n, state_reg != H_IDLE};
        default: RDATA <= 16'h0000;
      endcase
    end else begin
      RDATA <= 16'h0000;
    end
  end

endmodule

// file: sup_asserts.sv
// sup_asserts: checks on the link between host end and supervisor end.
// assumes one clock, sync active-high reset, device ms tick of MS cycles.
`timescale 1ns/100ps
module sup_asserts
  import sup_pkg::*;
#(
  parameter int MS = 20
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic chip_select_n,
  input wire logic frame_write,
  input wire logic [1:0] frame_addr,
  input wire logic [7:0] frame_data,
  input wire logic [7:0] read_data,
  input wire logic reset_out_n
);
  localparam int DLY_MIN = 9 * MS;
  logic [15:0] low_cnt_reg;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  // ****
  // low time of reset output
  // ****
  always_ff @(posedge CLK) begin
    if (RST || reset_out_n) begin
      low_cnt_reg <= 16'h0000;
    end else if (low_cnt_reg != 16'hFFFF) begin
      low_cnt_reg <= low_cnt_reg + 16'h0001;
    end
  end
  // ****
  // properties
  // ****
  sequence s_frame_start;
    $fell(chip_select_n);
  endsequence
  sequence s_frame_body;
    !chip_select_n [*3] ##[1:2] chip_select_n;
  endsequence
  property p_frame_len;
    s_frame_start |-> s_frame_body;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame length wrong");
  property p_frame_hold;
    !$past(chip_select_n) |-> $stable(frame_addr) && $stable(frame_data) && $stable(frame_write);
  endproperty
  a_frame_hold: assert property (p_frame_hold) else $error("frame lines moved");
  property p_parity;
    s_frame_start ##0 (frame_write && frame_addr == DEV_WDOG_CTRL) |-> (^frame_data) == 1'b0;
  endproperty
  a_parity: assert property (p_parity) else $error("odd parity sent");
  property p_rsvd;
    $past(frame_addr) == DEV_WDOG_CTRL |-> !read_data[WD_RSVD_BIT] && !read_data[WD_CHK_BIT];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit read as one");
  property p_fail_sat;
    $past(frame_addr) == DEV_SUP_STAT |-> read_data[1:0] != 2'h3;
  endproperty
  a_fail_sat: assert property (p_fail_sat) else $error("fail count past max");
  property p_mode_code;
    $past(frame_addr) == DEV_MODE_CTRL |-> read_data[7:3] == 5'h00 && read_data[2:0] <= 3'h5;
  endproperty
  a_mode_code: assert property (p_mode_code) else $error("bad mode code");
  property p_pwr_hold;
    $fell(RST) |-> !reset_out_n [*8];
  endproperty
  a_pwr_hold: assert property (p_pwr_hold) else $error("reset out released early");
  property p_rst_hold;
    $rose(reset_out_n) |-> int'(low_cnt_reg) >= DLY_MIN;
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("reset delay too short");
endmodule

// file: tb_top.sv
// tb_top: host and supervisor ends joined over the link, driven from the user port.
// assumes a 20 cycle ms tick; wake, fail-safe choice and config select are tied.
`timescale 1ns/100ps
module tb_top
  import sup_pkg::*;
;
  localparam int MS = 20;
  localparam int CEIL = 20000;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic vcc_uv = 1'b1;
  logic dev_mode = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic we = 1'b0;
  logic re = 1'b0;
  logic [15:0] rdata;
  logic [1:0] thr;
  int miscompares = 0;
  int checks_done = 0;
  int cyc = 0;
  sup_if u_sup_if ();
  sup_device #(.CYCLES_PER_MS(MS)) u_sup_device (.CLK(CLK), .RST(RST),
    .VCC_UNDERVOLTAGE(vcc_uv), .DEV_MODE(dev_mode), .WAKE(1'b0), .FAILSAFE_ON_WDOG(1'b0),
    .CFG_SEL(2'h0), .THRESHOLD_SEL(thr), .link(u_sup_if));
  sup_host u_sup_host (.CLK(CLK), .RST(RST), .ADDR(addr), .WDATA(wdata), .WE(we), .RE(re),
    .RDATA(rdata), .link(u_sup_if));
  sup_asserts #(.MS(MS)) u_sup_asserts (.CLK(CLK), .RST(RST),
    .chip_select_n(u_sup_if.chip_select_n), .frame_write(u_sup_if.frame_write),
    .frame_addr(u_sup_if.frame_addr), .frame_data(u_sup_if.frame_data),
    .read_data(u_sup_if.read_data), .reset_out_n(u_sup_if.reset_out_n));
  always #20 CLK = ~CLK;
  // ****
  // shared tasks
  // ****
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == CEIL) begin
      miscompares = miscompares + 1;
      report_and_stop();
    end
  end
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge CLK);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge CLK);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge CLK);
    addr <= a;
    re <= 1'b1;
    @(posedge CLK);
    re <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic frame(input logic [1:0] da, input logic w, input logic [7:0] d);
    logic [15:0] s;
    int n;
    wr(HOST_DATA, {8'h00, d});
    wr(HOST_CMD, {13'h0000, w, da});
    n = 0;
    s = 16'h0001;
    while (s[HOST_STAT_BUSY_BIT] !== 1'b0 && n < 20) begin
      rd(HOST_STAT, s);
      n++;
    end
    chk("host idle", 16'h0000, {15'h0000, s[HOST_STAT_BUSY_BIT]});
  endtask
  task automatic chk_dev(input string name, input logic [1:0] da, input logic [7:0] exp);
    logic [15:0] s;
    frame(da, 1'b0, 8'h00);
    rd(HOST_STAT, s);
    chk(name, {8'h00, exp}, {8'h00, s[15:8]});
  endtask
  task automatic wait_ro(input logic lvl, input int lim, output int n);
    n = 0;
    while (u_sup_if.reset_out_n !== lvl && n < lim) begin
      @(posedge CLK);
      #1;
      n++;
    end
  endtask
  task automatic chk_ro(input string name, input logic exp);
    chk(name, {15'h0000, exp}, {15'h0000, u_sup_if.reset_out_n});
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_power_up();
    int n;
    repeat (300) @(posedge CLK);
    #1;
    chk_ro("reset held", 1'b0);
    @(posedge CLK);
    vcc_uv <= 1'b0;
    wait_ro(1'b1, 260, n);
    chk("release delay", 16'h0001, {15'h0000, n >= 9 * MS && n <= 10 * MS + 8});
  endtask
  task automatic t_defaults();
    chk_dev("cfg default", DEV_SUP_CFG, 8'h01);
    chk("thr default", 16'h0000, {14'h0000, thr});
    frame(DEV_WDOG_CTRL, 1'b1, 8'h12);
    chk_dev("wdog kept", DEV_WDOG_CTRL, 8'h04);
    frame(DEV_MODE_CTRL, 1'b1, {6'h00, MODE_WR_SOFT_RESET});
    chk_dev("soft in init", DEV_MODE_CTRL, 8'h00);
  endtask
  task automatic t_soft(input logic drives_rst);
    int n;
    frame(DEV_MODE_CTRL, 1'b1, {6'h00, MODE_WR_NORMAL});
    chk_dev("mode normal", DEV_MODE_CTRL, 8'h01);
    frame(DEV_SUP_CFG, 1'b1, {5'h00, 2'h2, drives_rst});
    chk("thr set", 16'h0002, {14'h0000, thr});
    frame(DEV_MODE_CTRL, 1'b1, {6'h00, MODE_WR_SOFT_RESET});
    wait_ro(1'b0, 20, n);
    chk_ro("soft reset out", ~drives_rst);
    chk("thr cleared", 16'h0000, {14'h0000, thr});
    wait_ro(1'b1, 260, n);
    chk_dev("mode init", DEV_MODE_CTRL, 8'h00);
    chk_dev("cfg cleared", DEV_SUP_CFG, 8'h01);
  endtask
  task automatic t_timeout();
    int n;
    frame(DEV_MODE_CTRL, 1'b1, {6'h00, MODE_WR_NORMAL});
    frame(DEV_WDOG_CTRL, 1'b1, 8'h01);
    repeat (3) begin
      repeat (120) @(posedge CLK);
      frame(DEV_WDOG_CTRL, 1'b1, 8'h01);
    end
    chk_ro("served reset", 1'b1);
    wait_ro(1'b0, 260, n);
    chk("expiry", 16'h0001, {15'h0000, n >= 8 * MS && n <= 11 * MS});
    chk_dev("restart", DEV_MODE_CTRL, 8'h04);
    chk_dev("fail count", DEV_SUP_STAT, 8'h01);
    wait_ro(1'b1, 260, n);
    chk_dev("back normal", DEV_MODE_CTRL, 8'h01);
    frame(DEV_WDOG_CTRL, 1'b1, 8'h01);
    chk_dev("fail cleared", DEV_SUP_STAT, 8'h00);
  endtask
  task automatic t_window();
    int n;
    frame(DEV_WDOG_CTRL, 1'b1, 8'h11);
    repeat (150) @(posedge CLK);
    frame(DEV_WDOG_CTRL, 1'b1, 8'h11);
    chk_ro("open trigger", 1'b1);
    frame(DEV_WDOG_CTRL, 1'b1, 8'h11);
    wait_ro(1'b0, 10, n);
    chk_ro("closed trigger", 1'b0);
    wait_ro(1'b1, 260, n);
    chk_dev("window fail", DEV_SUP_STAT, 8'h01);
  endtask
  task automatic t_dev();
    @(posedge CLK);
    dev_mode <= 1'b1;
    repeat (4500) @(posedge CLK);
    #1;
    chk_ro("dev mode", 1'b1);
    @(posedge CLK);
    dev_mode <= 1'b0;
  endtask
  initial begin
    repeat (4) @(posedge CLK);
    RST <= 1'b0;
    t_power_up();
    t_defaults();
    t_soft(1'b1);
    t_soft(1'b0);
    t_timeout();
    t_window();
    t_dev();
    report_and_stop();
  end
endmodule
